//--- sdif_servo_inputs.sv
// Contact-input functions of the servo drive with a Wishbone register slave
`default_nettype none
// What this block does
// - Forward travel limit stops the motor and blocks forward motion.
// - Reverse travel limit stops the motor and blocks reverse motion.
// - Origin sensor is the reference switch that ends homing.
// - Servo-stop contact holds the motor stopped while active.
// - Proportional-only contact switches the loop from PI to P.
// - Gain-switch contact selects the second speed gain set.
// - Forward torque clamp contact enables forward torque limiting.
// - Reverse torque clamp contact enables reverse torque limiting.
// - Each touch latch edge captures the position into its own latch.
// - Emergency halt stops per stop-method setting and raises warning 80.
// - Alarm clear edge clears the active servo alarm.
// - Servo enable makes motor operable; off releases it to free run.
// - Index start edge begins the indexed position operation.
// - Homing start edge begins the homing operation.
// - Registration trigger in registration index types starts the preset move.
// - Six select contacts form index 0 to 63, optionally range-masked.
// - Pause during an index operation decelerates and holds paused.
// - Pause again while paused resumes the interrupted index operation.
// - Start, homing, registration and select act only in index mode.
// - Servo enable is ignored until 2 s after power-up.
module sdif_servo_inputs
	import sdif_pkg::*;
#(
	parameter int unsigned PWRUP_CYCLES = SDIF_PWRUP_CYCLES
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Contact inputs
	input  wire logic        fwd_travel_limit_i,
	input  wire logic        rev_travel_limit_i,
	input  wire logic        origin_sensor_i,
	input  wire logic        servo_stop_i,
	input  wire logic        prop_only_select_i,
	input  wire logic        second_gain_select_i,
	input  wire logic        fwd_torque_clamp_i,
	input  wire logic        rev_torque_clamp_i,
	input  wire logic        touch_latch_a_i,
	input  wire logic        touch_latch_b_i,
	input  wire logic        emergency_halt_i,
	input  wire logic        alarm_clear_i,
	input  wire logic        servo_enable_i,
	input  wire logic        index_start_i,
	input  wire logic        homing_start_i,
	input  wire logic        registration_trigger_i,
	input  wire logic        pause_i,
	input  wire logic        index_select_b0_i,
	input  wire logic        index_select_b1_i,
	input  wire logic        index_select_b2_i,
	input  wire logic        index_select_b3_i,
	input  wire logic        index_select_b4_i,
	input  wire logic        index_select_b5_i,
	// Drive core status
	input  wire logic [31:0] position_i,
	input  wire logic        alarm_raise_i,
	input  wire logic        motion_done_i,
	// Drive actions
	output logic             servo_on_o,
	output logic             free_run_o,
	output logic             motor_stop_o,
	output logic [1:0]       stop_cause_o,
	output logic [1:0]       stop_method_o,
	output logic             estop_o,
	output logic [7:0]       warning_code_o,
	output logic             fwd_block_o,
	output logic             rev_block_o,
	output logic             prop_only_o,
	output logic             gain_set2_o,
	output logic             fwd_tq_limit_o,
	output logic             rev_tq_limit_o,
	output logic             alarm_active_o,
	output logic [5:0]       index_num_o,
	output logic             index_run_o,
	output logic             homing_run_o,
	output logic             reg_move_o,
	output logic             paused_o,
	output logic             home_ref_o
);
	typedef struct packed {
		sdif_state_t state;
		sdif_state_t resume;
		logic [31:0] pwr_cnt;
		logic        ready;
		logic        idx_mode;
		logic [1:0]  stop_meth;
		logic [1:0]  idx_type;
		logic [5:0]  range_mask;
		logic        servo_on;
		logic        free_run;
		logic        motor_stop;
		logic [1:0]  cause;
		logic        estop;
		logic [7:0]  warn;
		logic        fwd_block;
		logic        rev_block;
		logic        prop_only;
		logic        second_gain_select;
		logic        fwd_tq;
		logic        rev_tq;
		logic        alarm;
		logic [31:0] probe_a;
		logic [31:0] probe_b;
		logic        flag_a;
		logic        flag_b;
		logic [5:0]  idx_num;
		logic        home_ref;
		logic        ack;
		logic [31:0] dat;
	} sdif_top_t;

	sdif_top_t s_r;
	sdif_top_t s_nxt;

	logic [SDIF_NIN-1:0] in_vec;
	logic [SDIF_NIN-1:0] lvl;
	logic [SDIF_NIN-1:0] rise;
	logic [5:0]          sel_vec;
	logic                any_stop;
	logic                start_ok;
	logic                req;
	logic [31:0]         rd_word;

	function automatic logic is_reg_type(input logic [1:0] t);
		is_reg_type = (t == ITYP_REGABS) || (t == ITYP_REGREL);
	endfunction : is_reg_type

	function automatic logic is_busy(input sdif_state_t st);
		is_busy = (st != SDIF_IDLE);
	endfunction : is_busy

	assign in_vec = {index_select_b5_i, index_select_b4_i, index_select_b3_i,
		index_select_b2_i, index_select_b1_i, index_select_b0_i, pause_i,
		registration_trigger_i, homing_start_i, index_start_i, servo_enable_i,
		alarm_clear_i, emergency_halt_i, touch_latch_b_i, touch_latch_a_i,
		rev_torque_clamp_i, fwd_torque_clamp_i, second_gain_select_i,
		prop_only_select_i, servo_stop_i, origin_sensor_i, rev_travel_limit_i,
		fwd_travel_limit_i};

	// All contacts cross into the clock domain here
	sdif_contact_cond #(
		.W(SDIF_NIN)
	) u_cond (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.raw_i  (in_vec),
		.level_o(lvl),
		.rise_o (rise)
	);

	assign sel_vec  = lvl[IN_SEL_HI:IN_SEL_LO];
	assign any_stop = lvl[IN_EMG] | lvl[IN_SVSTOP] | lvl[IN_FWD] | lvl[IN_REV];
	assign start_ok = s_r.idx_mode & ~any_stop & s_r.servo_on;
	assign req      = wb_cyc_i & wb_stb_i;

	// Register read mux
	always_comb begin
		rd_word = 32'h0;
		case (wb_adr_i)
			A_CTRL: begin
				rd_word[C_MODE] = s_r.idx_mode;
				rd_word[C_METH_LO +: 2] = s_r.stop_meth;
				rd_word[C_TYPE_LO +: 2] = s_r.idx_type;
				rd_word[C_MASK_LO +: 6] = s_r.range_mask;
			end
			A_STAT: begin
				rd_word[S_SERVO_ENABLE] = s_r.servo_on;
				rd_word[S_STOP] = s_r.motor_stop;
				rd_word[S_ESTOP] = s_r.estop;
				rd_word[S_ALARM] = s_r.alarm;
				rd_word[S_PAUSED] = (s_r.state == SDIF_PAUSED);
				rd_word[S_RDY] = s_r.ready;
				rd_word[S_CAUSE_LO +: 2] = s_r.cause;
				rd_word[S_WARN_LO +: 8] = s_r.warn;
				rd_word[S_IDX_LO +: 6] = s_r.idx_num;
				rd_word[S_STATE_LO +: 3] = s_r.state;
			end
			A_PRA: begin
				rd_word = s_r.probe_a;
			end
			A_PRB: begin
				rd_word = s_r.probe_b;
			end
			A_PFLG: begin
				rd_word[PF_A] = s_r.flag_a;
				rd_word[PF_B] = s_r.flag_b;
			end
			default: begin
				rd_word = 32'h0;
			end
		endcase
	end

	always_comb begin
		s_nxt = s_r;

		// Bus: ack one cycle after the request, write lands at the edge that ends the ack cycle
		s_nxt.ack = req & ~s_r.ack;
		if (req && !s_r.ack) begin
			s_nxt.dat = rd_word;
		end
		if (req && s_r.ack && wb_we_i) begin
			if (wb_adr_i == A_CTRL && wb_sel_i[0]) begin
				s_nxt.idx_mode = wb_dat_i[C_MODE];
				s_nxt.stop_meth = wb_dat_i[C_METH_LO +: 2];
				s_nxt.idx_type = wb_dat_i[C_TYPE_LO +: 2];
			end
			if (wb_adr_i == A_CTRL && wb_sel_i[1]) begin
				s_nxt.range_mask = wb_dat_i[C_MASK_LO +: 6];
			end
			if (wb_adr_i == A_PFLG && wb_sel_i[0]) begin
				s_nxt.flag_a = s_r.flag_a & ~wb_dat_i[PF_A];
				s_nxt.flag_b = s_r.flag_b & ~wb_dat_i[PF_B];
			end
		end

		// Power-up hold-off on servo enable
		if (!s_r.ready) begin
			s_nxt.pwr_cnt = s_r.pwr_cnt + 32'h1;
		end
		s_nxt.ready = s_r.ready | (s_r.pwr_cnt >= PWRUP_CYCLES - 1);
		s_nxt.servo_on = s_r.ready & lvl[IN_EN];
		s_nxt.free_run = ~(s_r.ready & lvl[IN_EN]);

		// Stop sources
		s_nxt.fwd_block = lvl[IN_FWD];
		s_nxt.rev_block = lvl[IN_REV];
		s_nxt.motor_stop = any_stop;
		s_nxt.estop = lvl[IN_EMG];
		s_nxt.warn = lvl[IN_EMG] ? SDIF_WARN_ESTOP : SDIF_WARN_NONE;
		if (lvl[IN_EMG]) begin
			s_nxt.cause = CAUSE_ESTOP;
		end else if (lvl[IN_SVSTOP]) begin
			s_nxt.cause = CAUSE_SVSTOP;
		end else if (lvl[IN_FWD] || lvl[IN_REV]) begin
			s_nxt.cause = CAUSE_LIMIT;
		end else begin
			s_nxt.cause = CAUSE_NONE;
		end

		// Loop and torque selections
		s_nxt.prop_only = lvl[IN_PROP_ONLY_SELECT];
		s_nxt.second_gain_select = lvl[IN_GAIN];
		s_nxt.fwd_tq = lvl[IN_FTQ];
		s_nxt.rev_tq = lvl[IN_RTQ];

		// Alarm: a new alarm wins over a clear
		if (rise[IN_ACLR]) begin
			s_nxt.alarm = 1'b0;
		end
		if (alarm_raise_i) begin
			s_nxt.alarm = 1'b1;
		end

		// Probe capture wins over a software clear
		if (rise[IN_PRA]) begin
			s_nxt.probe_a = position_i;
			s_nxt.flag_a = 1'b1;
		end
		if (rise[IN_PRB]) begin
			s_nxt.probe_b = position_i;
			s_nxt.flag_b = 1'b1;
		end

		// Index operation sequencer
		case (s_r.state)
			SDIF_IDLE: begin
				if (start_ok && rise[IN_ISTART]) begin
					s_nxt.state = SDIF_INDEX;
					s_nxt.idx_num = sel_vec & s_r.range_mask;
				end else if (start_ok && rise[IN_HOMING_START]) begin
					s_nxt.state = SDIF_HOMING;
				end
			end
			SDIF_INDEX: begin
				if (rise[IN_PAUSE]) begin
					s_nxt.state = SDIF_PAUSED;
					s_nxt.resume = SDIF_INDEX;
				end else if (rise[IN_REG] && s_r.idx_mode && is_reg_type(s_r.idx_type)) begin
					s_nxt.state = SDIF_REG;
				end else if (motion_done_i) begin
					s_nxt.state = SDIF_IDLE;
				end
			end
			SDIF_REG: begin
				if (rise[IN_PAUSE]) begin
					s_nxt.state = SDIF_PAUSED;
					s_nxt.resume = SDIF_REG;
				end else if (motion_done_i) begin
					s_nxt.state = SDIF_IDLE;
				end
			end
			SDIF_HOMING: begin
				if (lvl[IN_ORG]) begin
					s_nxt.state = SDIF_IDLE;
				end
			end
			SDIF_PAUSED: begin
				if (rise[IN_PAUSE]) begin
					s_nxt.state = s_r.resume;
				end
			end
			default: begin
				s_nxt.state = SDIF_IDLE;
			end
		endcase
		// Any stop or loss of enable aborts motion
		if (is_busy(s_r.state) && (any_stop || !s_r.servo_on)) begin
			s_nxt.state = SDIF_IDLE;
		end
		s_nxt.home_ref = lvl[IN_ORG] & (s_r.state == SDIF_HOMING);

		if (rst_i) begin
			s_nxt = '0;
			s_nxt.range_mask = SDIF_RST_MASK;
			s_nxt.free_run = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		s_r <= s_nxt;
	end

	assign wb_dat_o       = s_r.dat;
	assign wb_ack_o       = s_r.ack;
	assign servo_on_o     = s_r.servo_on;
	assign free_run_o     = s_r.free_run;
	assign motor_stop_o   = s_r.motor_stop;
	assign stop_cause_o   = s_r.cause;
	assign stop_method_o  = s_r.stop_meth;
	assign estop_o        = s_r.estop;
	assign warning_code_o = s_r.warn;
	assign fwd_block_o    = s_r.fwd_block;
	assign rev_block_o    = s_r.rev_block;
	assign prop_only_o    = s_r.prop_only;
	assign gain_set2_o    = s_r.second_gain_select;
	assign fwd_tq_limit_o = s_r.fwd_tq;
	assign rev_tq_limit_o = s_r.rev_tq;
	assign alarm_active_o = s_r.alarm;
	assign index_num_o    = s_r.idx_num;
	assign index_run_o    = (s_r.state == SDIF_INDEX);
	assign homing_run_o   = (s_r.state == SDIF_HOMING);
	assign reg_move_o     = (s_r.state == SDIF_REG);
	assign paused_o       = (s_r.state == SDIF_PAUSED);
	assign home_ref_o     = s_r.home_ref;

	// Checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence sq_pause_req;
		(s_r.state == SDIF_INDEX) && rise[IN_PAUSE] && !any_stop && s_r.servo_on;
	endsequence
	sequence sq_resume_req;
		(s_r.state == SDIF_PAUSED) && rise[IN_PAUSE] && !any_stop && s_r.servo_on
			&& (s_r.resume == SDIF_INDEX);
	endsequence

	a_fwd_limit_block: assert property (lvl[IN_FWD] |=> fwd_block_o && motor_stop_o)
		else $error("forward limit not enforced");
	a_rev_limit_block: assert property (lvl[IN_REV] |=> rev_block_o && motor_stop_o)
		else $error("reverse limit not enforced");
	a_homing_origin_end: assert property (homing_run_o && lvl[IN_ORG] |=> !homing_run_o)
		else $error("homing did not end on origin");
	a_servo_stop_hold: assert property (lvl[IN_SVSTOP] |=> motor_stop_o)
		else $error("servo stop not held");
	a_loop_select: assert property ($changed(lvl[IN_PROP_ONLY_SELECT]) |=> prop_only_o == $past(lvl[IN_PROP_ONLY_SELECT]))
		else $error("proportional select not followed");
	a_gain_select: assert property (lvl[IN_GAIN] ##1 lvl[IN_GAIN] |-> gain_set2_o)
		else $error("second gain not selected");
	a_torque_clamp: assert property (lvl[IN_FTQ] && lvl[IN_RTQ] |=> fwd_tq_limit_o && rev_tq_limit_o)
		else $error("torque clamp not enabled");
	a_probe_capture: assert property (rise[IN_PRA] |=> s_r.probe_a == $past(position_i) && s_r.flag_a)
		else $error("touch latch a missed");
	a_estop_warn: assert property (lvl[IN_EMG] |=> estop_o && warning_code_o == SDIF_WARN_ESTOP)
		else $error("emergency halt without warning");
	a_alarm_clear: assert property (alarm_active_o && rise[IN_ACLR] && !alarm_raise_i |=> !alarm_active_o)
		else $error("alarm not cleared");
	a_enable_free_run: assert property (s_r.ready && !lvl[IN_EN] |=> free_run_o && !servo_on_o)
		else $error("free run not entered");
	a_index_start: assert property (s_r.state == SDIF_IDLE && start_ok && rise[IN_ISTART] |=> index_run_o && index_num_o == ($past(sel_vec) & $past(s_r.range_mask)))
		else $error("index start not taken");
	a_registration_move: assert property (index_run_o && start_ok && is_reg_type(s_r.idx_type) && rise[IN_REG] && !rise[IN_PAUSE] |=> reg_move_o)
		else $error("registration move not started");
	a_pause_entry: assert property (sq_pause_req |=> paused_o)
		else $error("pause not entered");
	a_pause_resume: assert property (sq_resume_req |=> index_run_o)
		else $error("index operation not resumed");
	a_mode_gate: assert property (!s_r.idx_mode && s_r.state == SDIF_IDLE |=> s_r.state == SDIF_IDLE)
		else $error("motion started outside index mode");
	a_early_enable: assert property (!s_r.ready |-> !servo_on_o)
		else $error("servo enabled before hold-off");
	a_stop_priority: assert property (lvl[IN_EMG] |=> stop_cause_o == CAUSE_ESTOP)
		else $error("emergency halt not top priority");
endmodule : sdif_servo_inputs
`default_nettype wire

//--- sdif_pkg.sv
// Constants and types for the servo contact-input function block
`default_nettype none
package sdif_pkg;
	// Clock and power-up hold-off
	localparam int SDIF_CLK_HZ = 250_000_000;
	localparam int SDIF_PWRUP_MS = 2000;
	localparam int SDIF_PWRUP_CYCLES = (SDIF_CLK_HZ / 1000) * SDIF_PWRUP_MS;

	// Contact vector positions
	localparam int SDIF_NIN = 23;
	localparam int IN_FWD = 0;
	localparam int IN_REV = 1;
	localparam int IN_ORG = 2;
	localparam int IN_SVSTOP = 3;
	localparam int IN_PROP_ONLY_SELECT = 4;
	localparam int IN_GAIN = 5;
	localparam int IN_FTQ = 6;
	localparam int IN_RTQ = 7;
	localparam int IN_PRA = 8;
	localparam int IN_PRB = 9;
	localparam int IN_EMG = 10;
	localparam int IN_ACLR = 11;
	localparam int IN_EN = 12;
	localparam int IN_ISTART = 13;
	localparam int IN_HOMING_START = 14;
	localparam int IN_REG = 15;
	localparam int IN_PAUSE = 16;
	localparam int IN_SEL_LO = 17;
	localparam int IN_SEL_HI = 22;

	// Register byte addresses
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STAT = 8'h04;
	localparam logic [7:0] A_PRA = 8'h08;
	localparam logic [7:0] A_PRB = 8'h0C;
	localparam logic [7:0] A_PFLG = 8'h10;

	// Control fields and reset values
	localparam int C_MODE = 0;
	localparam int C_METH_LO = 1;
	localparam int C_TYPE_LO = 3;
	localparam int C_MASK_LO = 8;
	localparam logic [5:0] SDIF_RST_MASK = 6'h3F;

	// Status fields
	localparam int S_SERVO_ENABLE = 0;
	localparam int S_STOP = 1;
	localparam int S_ESTOP = 2;
	localparam int S_ALARM = 3;
	localparam int S_PAUSED = 4;
	localparam int S_RDY = 5;
	localparam int S_CAUSE_LO = 6;
	localparam int S_WARN_LO = 8;
	localparam int S_IDX_LO = 16;
	localparam int S_STATE_LO = 24;
	localparam int PF_A = 0;
	localparam int PF_B = 1;

	// Index types, stop causes, warning codes
	localparam logic [1:0] ITYP_REGABS = 2'h2;
	localparam logic [1:0] ITYP_REGREL = 2'h3;
	localparam logic [1:0] CAUSE_NONE = 2'h0;
	localparam logic [1:0] CAUSE_LIMIT = 2'h1;
	localparam logic [1:0] CAUSE_SVSTOP = 2'h2;
	localparam logic [1:0] CAUSE_ESTOP = 2'h3;
	localparam logic [7:0] SDIF_WARN_NONE = 8'h00;
	localparam logic [7:0] SDIF_WARN_ESTOP = 8'h50;

	typedef enum logic [2:0] {
		SDIF_IDLE   = 3'h0,
		SDIF_INDEX  = 3'h1,
		SDIF_HOMING = 3'h2,
		SDIF_PAUSED = 3'h3,
		SDIF_REG    = 3'h4
	} sdif_state_t;
endpackage : sdif_pkg
`default_nettype wire

//--- sdif_contact_cond.sv
// Two-flop synchroniser with rising-edge detect for the contact inputs
`default_nettype none
module sdif_contact_cond #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// Contacts
	input  wire logic [W-1:0] raw_i,
	output logic      [W-1:0] level_o,
	output logic      [W-1:0] rise_o
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
	} sdif_cond_t;

	sdif_cond_t s_r;
	sdif_cond_t s_nxt;

	always_comb begin
		s_nxt    = s_r;
		s_nxt.s1 = raw_i;
		s_nxt.s2 = s_r.s1;
		s_nxt.s3 = s_r.s2;
		if (rst_i) begin
			s_nxt = '0;
		end
	end

	always_ff @(posedge clk_i) begin
		s_r <= s_nxt;
	end

	// Only stage two and three feed the block
	assign level_o = s_r.s2;
	assign rise_o  = s_r.s2 & ~s_r.s3;
endmodule : sdif_contact_cond
`default_nettype wire

//--- sdif_field_model.sv
// Field-side model: position source, move completion and origin sensor
`default_nettype none
module sdif_field_model (
	// Clock
	input  wire logic        clk_i,
	// Bench control
	input  wire logic        load_i,
	input  wire logic [31:0] load_val_i,
	input  wire logic [7:0]  delay_i,
	// Drive activity
	input  wire logic        moving_i,
	input  wire logic        homing_i,
	// Field answers
	output logic      [31:0] position_o,
	output logic             done_o,
	output logic             origin_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] wait_r;
	initial begin
		position_o = 32'h0;
		wait_r = 8'h0;
	end
	// Position only moves while the drive is busy
	always @(posedge clk_i) begin
		position_o <= load_i ? load_val_i : position_o + {31'h0, moving_i | homing_i};
		if (!(moving_i | homing_i)) begin
			wait_r <= 8'h0;
		end else if (wait_r != delay_i) begin
			wait_r <= wait_r + 8'h1;
		end
	end
	// Completion held until the move drops
	assign done_o = moving_i && (wait_r == delay_i);
	assign origin_o = homing_i && (wait_r == delay_i);
endmodule : sdif_field_model
`default_nettype wire

//--- sdif_servo_inputs_bench.sv
// Self-checking bench for the servo contact-input block
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
	$display("MISMATCH t=%0t got %0h exp %0h", $time, g, e); end end
module sdif_servo_inputs_bench import sdif_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PW = 20;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic        wb_we_i = 1'b0;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [3:0]  wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	// Servo enable already on at power-up
	logic [22:0] ct = 23'h001000;
	logic        alarm_raise_i = 1'b0;
	logic        load = 1'b0;
	logic [31:0] load_val = 32'h0;
	logic [7:0]  dly = 8'hC8;
	logic [31:0] wb_dat_o, position_i, rd;
	logic        wb_ack_o, motion_done_i, origin_i, servo_on_o, free_run_o, motor_stop_o;
	logic        estop_o, fwd_block_o, rev_block_o, prop_only_o, gain_set2_o, fwd_tq_limit_o;
	logic        rev_tq_limit_o, alarm_active_o, index_run_o, homing_run_o, reg_move_o;
	logic        paused_o, home_ref_o;
	logic [1:0]  stop_cause_o, stop_method_o;
	logic [7:0]  warning_code_o;
	logic [5:0]  index_num_o;
	int          checked = 0;
	int          mismatches = 0;
	int          cycles = 0;
	int          n;

	sdif_servo_inputs #(.PWRUP_CYCLES(PW)) u_sdif_servo_inputs (
		.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
		.wb_dat_o, .wb_ack_o,
		.fwd_travel_limit_i(ct[IN_FWD]), .rev_travel_limit_i(ct[IN_REV]),
		.origin_sensor_i(origin_i), .servo_stop_i(ct[IN_SVSTOP]),
		.prop_only_select_i(ct[IN_PROP_ONLY_SELECT]), .second_gain_select_i(ct[IN_GAIN]),
		.fwd_torque_clamp_i(ct[IN_FTQ]), .rev_torque_clamp_i(ct[IN_RTQ]),
		.touch_latch_a_i(ct[IN_PRA]), .touch_latch_b_i(ct[IN_PRB]),
		.emergency_halt_i(ct[IN_EMG]), .alarm_clear_i(ct[IN_ACLR]),
		.servo_enable_i(ct[IN_EN]), .index_start_i(ct[IN_ISTART]),
		.homing_start_i(ct[IN_HOMING_START]), .registration_trigger_i(ct[IN_REG]),
		.pause_i(ct[IN_PAUSE]), .index_select_b0_i(ct[IN_SEL_LO]),
		.index_select_b1_i(ct[IN_SEL_LO+1]), .index_select_b2_i(ct[IN_SEL_LO+2]),
		.index_select_b3_i(ct[IN_SEL_LO+3]), .index_select_b4_i(ct[IN_SEL_LO+4]),
		.index_select_b5_i(ct[IN_SEL_HI]),
		.position_i, .alarm_raise_i, .motion_done_i, .servo_on_o, .free_run_o,
		.motor_stop_o, .stop_cause_o, .stop_method_o, .estop_o, .warning_code_o,
		.fwd_block_o, .rev_block_o, .prop_only_o, .gain_set2_o, .fwd_tq_limit_o,
		.rev_tq_limit_o, .alarm_active_o, .index_num_o, .index_run_o, .homing_run_o,
		.reg_move_o, .paused_o, .home_ref_o
	);
	sdif_field_model u_sdif_field_model (
		.clk_i, .load_i(load), .load_val_i(load_val), .delay_i(dly),
		.moving_i(index_run_o | reg_move_o), .homing_i(homing_run_o),
		.position_o(position_i), .done_o(motion_done_i), .origin_o(origin_i)
	);

	always #2 clk_i = ~clk_i;

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : print_verdict

	always @(posedge clk_i) begin
		cycles++;
		if (cycles > 6000) begin
			mismatches++;
			print_verdict();
		end
	end

	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'b11, we, 4'hF};
		wb_adr_i <= a;
		wb_dat_i <= d;
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1) @(posedge clk_i);
		rd = wb_dat_o;
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= 7'h00;
	endtask : wb

	// Contact change, then wait past the synchroniser
	task automatic lv(input int i, input logic v);
		@(posedge clk_i);
		ct[i] <= v;
		repeat (4) @(posedge clk_i);
		@(negedge clk_i);
	endtask : lv

	task automatic pulse(input int i);
		lv(i, 1'b1);
		lv(i, 1'b0);
	endtask : pulse

	task automatic t_holdoff();
		@(negedge clk_i);
		`CHK(free_run_o, 1'b1)
		repeat (PW - 2) @(posedge clk_i);
		@(negedge clk_i);
		`CHK(servo_on_o, 1'b0)
		repeat (8) @(posedge clk_i);
		@(negedge clk_i);
		`CHK(servo_on_o, 1'b1)
		`CHK(free_run_o, 1'b0)
		$display("t_holdoff done");
	endtask : t_holdoff

	task automatic t_bus();
		wb(1'b0, A_CTRL, 32'h0);
		`CHK(rd, 32'h00003F00)
		wb(1'b1, 8'h44, 32'hFFFFFFFF);
		wb(1'b0, 8'h44, 32'h0);
		`CHK(rd, 32'h0)
		wb(1'b0, A_CTRL, 32'h0);
		`CHK(rd, 32'h00003F00)
		$display("t_bus done");
	endtask : t_bus

	task automatic t_levels();
		for (n = IN_PROP_ONLY_SELECT; n <= IN_RTQ; n++) lv(n, 1'b1);
		`CHK({prop_only_o, gain_set2_o}, 2'b11)
		`CHK({fwd_tq_limit_o, rev_tq_limit_o}, 2'b11)
		for (n = IN_PROP_ONLY_SELECT; n <= IN_RTQ; n++) lv(n, 1'b0);
		`CHK({prop_only_o, gain_set2_o, fwd_tq_limit_o, rev_tq_limit_o}, 4'h0)
		lv(IN_FWD, 1'b1);
		`CHK({motor_stop_o, fwd_block_o, rev_block_o}, 3'b110)
		`CHK(stop_cause_o, CAUSE_LIMIT)
		lv(IN_FWD, 1'b0);
		lv(IN_REV, 1'b1);
		`CHK({motor_stop_o, fwd_block_o, rev_block_o}, 3'b101)
		lv(IN_REV, 1'b0);
		lv(IN_SVSTOP, 1'b1);
		`CHK(stop_cause_o, CAUSE_SVSTOP)
		lv(IN_EMG, 1'b1);
		`CHK(stop_cause_o, CAUSE_ESTOP)
		`CHK({estop_o, warning_code_o}, {1'b1, 8'h50})
		lv(IN_EMG, 1'b0);
		`CHK(warning_code_o, SDIF_WARN_NONE)
		lv(IN_SVSTOP, 1'b0);
		`CHK({motor_stop_o, stop_cause_o}, 3'b000)
		$display("t_levels done");
	endtask : t_levels

	task automatic t_index();
		@(posedge clk_i);
		ct[IN_SEL_HI:IN_SEL_LO] <= 6'h2A;
		pulse(IN_ISTART);
		`CHK(index_run_o, 1'b0)
		pulse(IN_HOMING_START);
		`CHK(homing_run_o, 1'b0)
		wb(1'b1, A_CTRL, 32'h00003F05);
		lv(IN_SVSTOP, 1'b1);
		`CHK(stop_method_o, 2'h2)
		pulse(IN_ISTART);
		`CHK(index_run_o, 1'b0)
		lv(IN_SVSTOP, 1'b0);
		pulse(IN_ISTART);
		`CHK({index_run_o, index_num_o}, {1'b1, 6'h2A})
		pulse(IN_PAUSE);
		`CHK({paused_o, index_run_o}, 2'b10)
		pulse(IN_PAUSE);
		`CHK({paused_o, index_run_o}, 2'b01)
		pulse(IN_REG);
		`CHK({reg_move_o, index_run_o}, 2'b01)
		for (n = 0; n < 400 && index_run_o; n++) @(negedge clk_i);
		`CHK(index_run_o, 1'b0)
		wb(1'b1, A_CTRL, 32'h00000F11);
		pulse(IN_ISTART);
		`CHK(index_num_o, 6'h0A)
		pulse(IN_REG);
		`CHK(reg_move_o, 1'b1)
		for (n = 0; n < 400 && reg_move_o; n++) @(negedge clk_i);
		`CHK(reg_move_o, 1'b0)
		@(posedge clk_i);
		dly <= 8'h1E;
		pulse(IN_HOMING_START);
		`CHK({homing_run_o, home_ref_o}, 2'b10)
		for (n = 0; n < 100 && homing_run_o; n++) @(negedge clk_i);
		`CHK({homing_run_o, home_ref_o}, 2'b01)
		$display("t_index done");
	endtask : t_index

	task automatic t_probe();
		@(posedge clk_i);
		{load, load_val} <= {1'b1, 32'hA5C30F96};
		@(posedge clk_i);
		load <= 1'b0;
		pulse(IN_PRA);
		wb(1'b0, A_PRA, 32'h0);
		`CHK(rd, 32'hA5C30F96)
		wb(1'b0, A_PFLG, 32'h0);
		`CHK(rd, 32'h1)
		wb(1'b1, A_PFLG, 32'h1);
		wb(1'b0, A_PFLG, 32'h0);
		`CHK(rd, 32'h0)
		{load, load_val} <= {1'b1, 32'h5A3CF069};
		@(posedge clk_i);
		load <= 1'b0;
		pulse(IN_PRB);
		wb(1'b0, A_PRB, 32'h0);
		`CHK(rd, 32'h5A3CF069)
		$display("t_probe done");
	endtask : t_probe

	task automatic t_alarm_off();
		@(posedge clk_i);
		alarm_raise_i <= 1'b1;
		@(posedge clk_i);
		alarm_raise_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		@(negedge clk_i);
		`CHK(alarm_active_o, 1'b1)
		pulse(IN_ACLR);
		`CHK(alarm_active_o, 1'b0)
		lv(IN_EN, 1'b0);
		`CHK({servo_on_o, free_run_o}, 2'b01)
		$display("t_alarm_off done");
	endtask : t_alarm_off

	// Mid-run reset must restore the reset values
	task automatic t_reset();
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		`CHK({free_run_o, servo_on_o, alarm_active_o, index_run_o}, 4'h8)
		wb(1'b0, A_CTRL, 32'h0);
		`CHK(rd, 32'h00003F00)
		$display("t_reset done");
	endtask : t_reset

	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		t_holdoff();
		t_bus();
		t_levels();
		t_index();
		t_probe();
		t_alarm_off();
		t_reset();
		print_verdict();
	end
endmodule : sdif_servo_inputs_bench
`default_nettype wire
